// ==== request_delivery_defs.svh ====
`ifndef REQUEST_DELIVERY_DEFS_SVH
`define REQUEST_DELIVERY_DEFS_SVH
// Functional notes
// - A memory read goes out as its 16-byte descriptor alone, no payload.
// - Payload-free packets take two beats on this 64-bit port.
// - Valid stays high through a packet; the receiver may stall beats.
// - The sop sideband flag marks the beat holding the first descriptor byte.
// - First and last byte masks ride the first beat; receiver derives address and size.
// - Byte masks may have gaps only for one- or two-Dword reads; the code keeps gaps in any request of up to two Dwords.
// - Zero-length read: Dword count 1, both byte masks zero.
// - I/O write carries one payload Dword, placed by alignment mode.
// - I/O read asks one Dword; first mask marks bytes; answer one Dword.
// - Atomic payload is one to eight Dwords, placed by alignment mode.
// - Message payload follows descriptor, or new beat at lane 0; masks meaningless.
// - Payload memory error raises discontinue with last; packet is dropped, fatal.
// - Posted requests keep flowing while Non-Posted wait; else arrival order.
// - Credit request high and no Non-Posted sent: count up, saturate at 32.
// - Credit request low and Non-Posted sent: count down, floor zero.
// - A Non-Posted request starts only while credit is above zero.
// - After a hold, older held Non-Posted go first, then arrival order.
// - Credit clears at reset and shows on a six-bit level output.
`define QUEUE_DEPTH 4
`define CREDIT_MAX 6'h20
`define KIND_MEM_READ 4'h0
`define KIND_MEM_WRITE 4'h1
`define KIND_IO_READ 4'h2
`define KIND_IO_WRITE 4'h3
`define KIND_LOCK_READ 4'h7
`define KIND_MESSAGE 4'hC
`define MAX_PAYLOAD_DW 4'h8
`define SB_LEADING_DWORD_BYTE_MASK 0
`define SB_LAST_BE 4
`define SB_BYTE_EN 8
`define SB_SOP 16
`define SB_DISCONTINUE 17
`define SB_WIDTH 18
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define CTRL_ADDR_ALIGNED 0
`define STAT_CREDIT 0
`define STAT_FATAL 6
`define STAT_QUEUE 8
`define STAT_BUSY 12
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== request_delivery_pkg.sv ====
`include "request_delivery_defs.svh"
package request_delivery_pkg;
  typedef enum logic {send_idle, send_busy} send_state_t;
  typedef struct packed {
    logic posted;
    logic zero_length;
    logic [3:0] kind;
    logic [63:0] address;
    logic [10:0] dword_count;
    logic [3:0] leading_dword_byte_mask;
    logic [3:0] last_be;
    logic [31:0] tag_word;
    logic [255:0] payload;
    logic payload_error;
    logic [3:0] payload_dwords;
  } request_entry_t;
endpackage : request_delivery_pkg

// ==== completer_request_delivery.sv ====
// Added by the designer: the register addresses and register access over AXI4-Lite.
`include "request_delivery_defs.svh"
module completer_request_delivery (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_request_valid,
  output logic link_request_ready,
  input wire logic [3:0] link_request_kind,
  input wire logic [63:0] link_request_address,
  input wire logic [10:0] link_request_dword_count,
  input wire logic link_request_zero_length,
  input wire logic [3:0] link_request_leading_dword_byte_mask,
  input wire logic [3:0] link_request_last_be,
  input wire logic [31:0] link_request_tag_word,
  input wire logic [255:0] link_request_payload,
  input wire logic link_request_payload_error,
  output logic [63:0] request_stream_data,
  output logic [1:0] request_stream_keep,
  output logic request_stream_last,
  output logic request_stream_valid,
  input wire logic request_stream_ready,
  output logic [`SB_WIDTH-1:0] request_sideband_bus,
  input wire logic nonposted_credit_request,
  output logic [5:0] nonposted_credit_level,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  request_delivery_pkg::request_entry_t queue [`QUEUE_DEPTH];
  request_delivery_pkg::request_entry_t next_queue [`QUEUE_DEPTH];
  request_delivery_pkg::request_entry_t incoming;
  request_delivery_pkg::request_entry_t cur;
  request_delivery_pkg::send_state_t state;
  logic [2:0] queue_count;
  logic [2:0] next_queue_count;
  logic pick_found;
  logic [1:0] pick_index;
  logic take;
  logic np_start;
  logic out_free;
  logic addr_aligned;
  logic fatal_seen;
  logic cur_pad;
  logic [2:0] beat_index;
  logic [4:0] total_dw;
  logic [2:0] last_index;
  logic [127:0] cur_desc;
  logic [4:0] lane_dw;
  logic [4:0] pay_dw;
  logic [63:0] beat_data;
  logic [1:0] beat_keep;
  logic [7:0] beat_byte_en;
  logic beat_last;
  logic expect_first;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [3:0] smear_up(input logic [3:0] m);
    logic [3:0] r;
    r = m | {m[2:0], 1'b0};
    return r | {r[1:0], 2'h0};
  endfunction : smear_up

  function automatic logic [3:0] smear_down(input logic [3:0] m);
    logic [3:0] r;
    r = m | {1'b0, m[3:1]};
    return r | {2'h0, r[3:2]};
  endfunction : smear_down

  assign out_free = !request_stream_valid || request_stream_ready;

  // Masks of any request longer than two Dwords, except I/O reads and writes, are forced contiguous so a malformed header cannot leak gaps.
  always_comb
  begin
    logic rd;
    logic [10:0] cnt;
    rd = link_request_kind == `KIND_MEM_READ || link_request_kind == `KIND_LOCK_READ;
    cnt = link_request_dword_count;
    incoming = '0;
    incoming.kind = link_request_kind;
    incoming.address = link_request_address;
    incoming.tag_word = link_request_tag_word;
    incoming.payload = link_request_payload;
    incoming.payload_error = link_request_payload_error;
    incoming.posted = link_request_kind == `KIND_MEM_WRITE
      || link_request_kind[3:2] == 2'h3;
    incoming.dword_count = cnt;
    incoming.leading_dword_byte_mask = link_request_leading_dword_byte_mask;
    incoming.last_be = link_request_last_be;
    if (cnt > 11'h002)
    begin
      incoming.leading_dword_byte_mask = smear_up(link_request_leading_dword_byte_mask);
      incoming.last_be = smear_down(link_request_last_be);
    end
    if (rd && link_request_zero_length)
    begin
      incoming.zero_length = 1'b1;
      incoming.dword_count = 11'h001;
      incoming.leading_dword_byte_mask = 4'h0;
      incoming.last_be = 4'h0;
    end
    if (link_request_kind == `KIND_IO_READ || link_request_kind == `KIND_IO_WRITE)
    begin
      incoming.dword_count = 11'h001;
      incoming.leading_dword_byte_mask = link_request_leading_dword_byte_mask;
      incoming.last_be = 4'h0;
    end
    if (rd || link_request_kind == `KIND_IO_READ)
      incoming.payload_dwords = 4'h0;
    else if (link_request_kind == `KIND_IO_WRITE)
      incoming.payload_dwords = 4'h1;
    else if (cnt > 11'(`MAX_PAYLOAD_DW))
      incoming.payload_dwords = `MAX_PAYLOAD_DW;
    else
      incoming.payload_dwords = cnt[3:0];
  end

  // The oldest eligible entry wins, so held Non-Posted requests older than sent
  // Posted ones leave first once credit returns.
  always_comb
  begin
    pick_found = 1'b0;
    pick_index = 2'h0;
    for (int i = `QUEUE_DEPTH - 1; i >= 0; i--)
    begin
      if (3'(i) < queue_count && (queue[i].posted || nonposted_credit_level != 6'h00))
      begin
        pick_found = 1'b1;
        pick_index = 2'(i);
      end
    end
  end

  assign take = pick_found && state == request_delivery_pkg::send_idle && out_free;
  assign np_start = take && !queue[pick_index].posted;

  always_comb
  begin
    next_queue = queue;
    next_queue_count = queue_count;
    if (take)
    begin
      for (int i = 0; i < `QUEUE_DEPTH - 1; i++)
      begin
        if (2'(i) >= pick_index)
          next_queue[i] = queue[i + 1];
      end
      next_queue_count = queue_count - 3'h1;
    end
    if (link_request_valid && link_request_ready)
    begin
      next_queue[next_queue_count[1:0]] = incoming;
      next_queue_count = next_queue_count + 3'h1;
    end
  end

  always_ff @(posedge clock)
    queue <= next_queue;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      queue_count <= 3'h0;
      link_request_ready <= 1'b1;
    end
    else
    begin
      queue_count <= next_queue_count;
      link_request_ready <= next_queue_count < 3'(`QUEUE_DEPTH);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      nonposted_credit_level <= 6'h00;
    else if (nonposted_credit_request && !np_start)
    begin
      if (nonposted_credit_level != `CREDIT_MAX)
        nonposted_credit_level <= nonposted_credit_level + 6'h01;
    end
    else if (!nonposted_credit_request && np_start)
    begin
      if (nonposted_credit_level != 6'h00)
        nonposted_credit_level <= nonposted_credit_level - 6'h01;
    end
  end

  assign cur_desc = {cur.tag_word, 17'h0, cur.kind, cur.dword_count, cur.address};
  assign total_dw = 5'h04 + {4'h0, cur_pad} + {1'b0, cur.payload_dwords};
  assign last_index = 3'((total_dw - 5'h01) >> 1);
  assign beat_last = beat_index == last_index;

  always_comb
  begin
    beat_data = '0;
    beat_keep = '0;
    beat_byte_en = '0;
    lane_dw = '0;
    pay_dw = '0;
    for (int l = 0; l < 2; l++)
    begin
      lane_dw = 5'({beat_index, 1'b0} + l);
      pay_dw = lane_dw - 5'h04 - {4'h0, cur_pad};
      if (lane_dw < 5'h04)
      begin
        beat_data[32*l +: 32] = cur_desc[32*lane_dw[1:0] +: 32];
        beat_keep[l] = 1'b1;
      end
      else if (lane_dw < total_dw)
      begin
        beat_keep[l] = 1'b1;
        if (lane_dw >= 5'h04 + {4'h0, cur_pad})
        begin
          beat_data[32*l +: 32] = cur.payload[32*pay_dw[2:0] +: 32];
          if (cur.kind != `KIND_MEM_WRITE && cur.kind != `KIND_IO_WRITE)
            beat_byte_en[4*l +: 4] = 4'hF;
          else if (pay_dw == 5'h00)
            beat_byte_en[4*l +: 4] = cur.leading_dword_byte_mask;
          else if (pay_dw == 5'({1'b0, cur.payload_dwords} - 5'h01))
            beat_byte_en[4*l +: 4] = cur.last_be;
          else
            beat_byte_en[4*l +: 4] = 4'hF;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (take)
    begin
      cur <= queue[pick_index];
      cur_pad <= addr_aligned && queue[pick_index].payload_dwords != 4'h0
        && queue[pick_index].kind[3:2] != 2'h3
        && queue[pick_index].address[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= request_delivery_pkg::send_idle;
      beat_index <= 3'h0;
      request_stream_valid <= 1'b0;
      request_stream_last <= 1'b0;
      request_stream_data <= '0;
      request_stream_keep <= 2'h0;
      request_sideband_bus <= '0;
      fatal_seen <= 1'b0;
    end
    else if (out_free)
    begin
      case (state)
        request_delivery_pkg::send_idle:
        begin
          request_stream_valid <= 1'b0;
          request_stream_last <= 1'b0;
          beat_index <= 3'h0;
          if (take)
            state <= request_delivery_pkg::send_busy;
        end
        request_delivery_pkg::send_busy:
        begin
          request_stream_valid <= 1'b1;
          request_stream_data <= beat_data;
          request_stream_keep <= beat_keep;
          request_stream_last <= beat_last;
          request_sideband_bus <= '0;
          request_sideband_bus[`SB_BYTE_EN +: 8] <= beat_byte_en;
          if (beat_index == 3'h0)
          begin
            request_sideband_bus[`SB_SOP] <= 1'b1;
            request_sideband_bus[`SB_LEADING_DWORD_BYTE_MASK +: 4] <= cur.leading_dword_byte_mask;
            request_sideband_bus[`SB_LAST_BE +: 4] <= cur.last_be;
          end
          if (beat_last && cur.payload_error && cur.payload_dwords != 4'h0)
          begin
            request_sideband_bus[`SB_DISCONTINUE] <= 1'b1;
            fatal_seen <= 1'b1;
          end
          beat_index <= beat_index + 3'h1;
          if (beat_last)
            state <= request_delivery_pkg::send_idle;
        end
        default:
          state <= request_delivery_pkg::send_idle;
      endcase
    end
  end

  // Write address and data may arrive in either order; the answer waits for both.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      addr_aligned <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bresp <= `RESP_SLVERR;
        if (aw_addr[11:2] == `REG_CONTROL >> 2)
        begin
          s_axi_bresp <= `RESP_OKAY;
          if (w_strb[0])
            addr_aligned <= w_data[`CTRL_ADDR_ALIGNED];
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
      if (s_axi_araddr[11:2] == `REG_CONTROL >> 2)
        s_axi_rdata[`CTRL_ADDR_ALIGNED] <= addr_aligned;
      else if (s_axi_araddr[11:2] == `REG_STATUS >> 2)
      begin
        s_axi_rdata[`STAT_CREDIT +: 6] <= nonposted_credit_level;
        s_axi_rdata[`STAT_FATAL] <= fatal_seen;
        s_axi_rdata[`STAT_QUEUE +: 3] <= queue_count;
        s_axi_rdata[`STAT_BUSY] <= state == request_delivery_pkg::send_busy;
      end
      else
        s_axi_rresp <= `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      expect_first <= 1'b1;
    else if (request_stream_valid && request_stream_ready)
      expect_first <= request_stream_last;
  end

  a_stall_holds: assert property (@(posedge clock) disable iff (!rst_n)
    request_stream_valid && !request_stream_ready |=> request_stream_valid
    && $stable(request_stream_data) && $stable(request_stream_last))
    else $error("Stalled beat changed.");
  a_sop_first: assert property (@(posedge clock) disable iff (!rst_n)
    request_stream_valid |-> request_sideband_bus[`SB_SOP] == expect_first)
    else $error("Start flag not on first beat.");
  a_bare_two_beats: assert property (@(posedge clock) disable iff (!rst_n)
    request_stream_valid && cur.payload_dwords == 4'h0
    |-> request_stream_last == !request_sideband_bus[`SB_SOP])
    else $error("Payload-free packet not two beats.");
  a_zero_len_masks: assert property (@(posedge clock) disable iff (!rst_n)
    request_stream_valid && request_sideband_bus[`SB_SOP] && cur.zero_length
    |-> request_sideband_bus[`SB_LEADING_DWORD_BYTE_MASK +: 8] == 8'h00 && cur.dword_count == 11'h001)
    else $error("Zero-length read masks wrong.");
  a_masks_contig: assert property (@(posedge clock) disable iff (!rst_n)
    request_stream_valid && request_sideband_bus[`SB_SOP] && cur.dword_count > 11'h002
    |-> smear_up(request_sideband_bus[`SB_LEADING_DWORD_BYTE_MASK +: 4])
    == request_sideband_bus[`SB_LEADING_DWORD_BYTE_MASK +: 4]
    && smear_down(request_sideband_bus[`SB_LAST_BE +: 4])
    == request_sideband_bus[`SB_LAST_BE +: 4])
    else $error("Long read mask has a gap.");
  a_abort_last: assert property (@(posedge clock) disable iff (!rst_n)
    request_sideband_bus[`SB_DISCONTINUE] && request_stream_valid |-> request_stream_last)
    else $error("Discontinue off the last beat.");
  a_credit_up: assert property (@(posedge clock) disable iff (!rst_n)
    nonposted_credit_request && !np_start && nonposted_credit_level < `CREDIT_MAX
    |=> nonposted_credit_level == $past(nonposted_credit_level) + 6'h01)
    else $error("Credit did not count up.");
  a_credit_down: assert property (@(posedge clock) disable iff (!rst_n)
    !nonposted_credit_request && np_start
    |=> nonposted_credit_level == $past(nonposted_credit_level) - 6'h01)
    else $error("Credit did not count down.");
  a_np_needs_credit: assert property (@(posedge clock) disable iff (!rst_n)
    np_start |-> nonposted_credit_level != 6'h00)
    else $error("Non-Posted start without credit.");
  a_posted_flows: assert property (@(posedge clock) disable iff (!rst_n)
    state == request_delivery_pkg::send_idle && out_free && queue_count != 3'h0
    && queue[0].posted |-> take && pick_index == 2'h0)
    else $error("Oldest Posted request held.");
endmodule : completer_request_delivery

// ==== user_completer_model.sv ====
module user_completer_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [63:0] data,
  input wire logic [1:0] keep,
  input wire logic last,
  input wire logic valid,
  input wire logic [17:0] sideband,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [84:0] beats [$];
  int dropped;
  logic second;
  int owed_read;
  int owed_io_write;
  int owed_atomic;
  // Ready drops at random, mid-packet too, so every beat may be stretched.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready <= 1'b0;
      dropped <= 0;
      second <= 1'b0;
      owed_read <= 0;
      owed_io_write <= 0;
      owed_atomic <= 0;
    end
    else
    begin
      ready <= $urandom_range(0, 2) != 0;
      if (valid && ready)
        beats.push_back({sideband, last, keep, data});
      // A discontinued packet is counted as dropped; the bench still inspects its beats.
      if (valid && ready && last && sideband[17])
        dropped <= dropped + 1;
      if (valid && ready)
        second <= sideband[16];
      // Every Non-Posted request leaves one completion owed, known from the descriptor kind.
      if (valid && ready && second)
      begin
        if (data[14:11] inside {4'h0, 4'h2, 4'h7})
          owed_read <= owed_read + 1;
        if (data[14:11] == 4'h3)
          owed_io_write <= owed_io_write + 1;
        if (data[14:11] inside {[4'h4:4'h6]})
          owed_atomic <= owed_atomic + 1;
      end
    end
  end
endmodule : user_completer_model

// ==== testbench.sv ====
`define check_eq(g, x) \
  begin \
    comparisons++; \
    if ((g) !== (x)) \
    begin \
      n_mismatch++; \
      $display("Error at %0t: got %0h, expected %0h", $time, (g), (x)); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] k;
    logic [63:0] a;
    logic [10:0] n;
    logic z;
    logic [3:0] f;
    logic [3:0] l;
    logic [31:0] tg;
    logic [255:0] p;
    logic e;
  } req_t;
  logic clock, rst_n, lvalid, lready, svalid, sready, slast, np_req;
  logic awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
  logic [1:0] skeep, bresp, rresp;
  logic [17:0] ssb, sb0;
  logic [63:0] sdata;
  logic [5:0] level;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  req_t cur;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [3:0] kinds [0:10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE};

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic [3:0] exp_be(input req_t r, input int x, input int pad, input int tot);
    if (x < 4 + pad || x >= tot)
      return 4'h0;
    if (r.k == 4'h3 || (r.k == 4'h1 && x == 4 + pad))
      return r.f;
    if (r.k == 4'h1 && x == tot - 1)
      return r.l;
    return 4'hF;
  endfunction : exp_be

  function automatic logic contig(input logic [7:0] m);
    return m[3:0] inside {4'hF, 4'hE, 4'hC, 4'h8} && m[7:4] inside {4'hF, 4'h7, 4'h3, 4'h1};
  endfunction : contig

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("Error at %0t: wait limit reached", $time);
      report_and_stop;
    end
  endtask : guard

  // Ready is registered, so its level before the edge decides that edge.
  task automatic send(input req_t r, input logic hold);
    logic tk;
    int t;
    t = 0;
    cur <= r;
    lvalid <= 1'b1;
    do
    begin
      @(negedge clock);
      tk = lready;
      @(posedge clock);
      t++;
    end
    while (tk !== 1'b1 && t < 100);
    if (!hold)
      lvalid <= 1'b0;
    guard(tk);
  endtask : send

  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er, output logic [31:0] q);
    logic ha, hw, hr, dn;
    logic [1:0] rs;
    int t;
    t = 0;
    dn = 1'b0;
    @(posedge clock);
    if (wr)
    begin
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arv <= 1'b1;
      rry <= 1'b1;
    end
    while (dn !== 1'b1 && t < 100)
    begin
      @(negedge clock);
      ha = awv && awr;
      hw = wv && wrd;
      hr = arv && arr;
      dn = wr ? bv : rv;
      rs = wr ? bresp : rresp;
      q = rdata;
      @(posedge clock);
      t++;
      if (ha)
        awv <= 1'b0;
      if (hw)
        wv <= 1'b0;
      if (hr)
        arv <= 1'b0;
    end
    bry <= 1'b0;
    rry <= 1'b0;
    guard(dn);
    `check_eq(rs, er)
  endtask : axi

  task automatic expect_pkt(input req_t r, input logic al, input logic cm);
    logic [84:0] b;
    logic [17:0] sb;
    logic [31:0] dw [0:3];
    logic io, rd;
    int pad, tot, nb, x, t;
    io = r.k == 4'h2 || r.k == 4'h3;
    rd = r.k == 4'h0 || r.k == 4'h2 || r.k == 4'h7;
    pad = (al && r.a[2] && r.k inside {4'h1, [4'h3:4'h6]}) ? 1 : 0;
    tot = 4 + pad + (rd ? 0 : (io ? 1 : int'(r.n)));
    nb = (tot + 1) / 2;
    dw[0] = r.a[31:0];
    dw[1] = r.a[63:32];
    dw[2] = {17'h0, r.k, (io || r.z) ? 11'h1 : r.n};
    dw[3] = r.tg;
    t = 0;
    while (user_completer_model_inst.beats.size() < nb && t < 300)
    begin
      @(posedge clock);
      t++;
    end
    guard(t < 300);
    for (int i = 0; i < nb; i++)
    begin
      b = user_completer_model_inst.beats.pop_front();
      sb = b[84:67];
      if (i == 0)
        sb0 = sb;
      `check_eq(b[66], i == nb - 1)
      `check_eq(b[65:64], {2 * i + 1 < tot, 1'b1})
      `check_eq(sb[16], i == 0)
      `check_eq(sb[17], r.e && i == nb - 1)
      if (cm || i > 0)
        `check_eq(sb[7:0], i > 0 ? 8'h0 : {(io || r.z) ? 4'h0 : r.l, r.z ? 4'h0 : r.f})
      for (int j = 0; j < 2; j++)
      begin
        x = 2 * i + j;
        `check_eq(sb[8 + 4 * j +: 4], exp_be(r, x, pad, tot))
        if (x < 4)
          `check_eq(b[32 * j +: 32], dw[x])
        else if (x >= 4 + pad && x < tot)
          `check_eq(b[32 * j +: 32], r.p[32 * (x - 4 - pad) +: 32])
      end
    end
  endtask : expect_pkt

  completer_request_delivery completer_request_delivery_inst (
    .clock(clock), .rst_n(rst_n), .link_request_valid(lvalid), .link_request_ready(lready),
    .link_request_kind(cur.k), .link_request_address(cur.a), .link_request_dword_count(cur.n),
    .link_request_zero_length(cur.z), .link_request_leading_dword_byte_mask(cur.f),
    .link_request_last_be(cur.l), .link_request_tag_word(cur.tg), .link_request_payload(cur.p),
    .link_request_payload_error(cur.e), .request_stream_data(sdata),
    .request_stream_keep(skeep), .request_stream_last(slast), .request_stream_valid(svalid),
    .request_stream_ready(sready), .request_sideband_bus(ssb),
    .nonposted_credit_request(np_req), .nonposted_credit_level(level),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry)
  );

  user_completer_model user_completer_model_inst (
    .clock(clock), .rst_n(rst_n), .data(sdata), .keep(skeep), .last(slast), .valid(svalid),
    .sideband(ssb), .ready(sready)
  );

  initial
  begin
    req_t r;
    req_t rq [0:3];
    logic [31:0] q;
    int np;
    void'($urandom(32'h7C44));
    rst_n = 1'b0;
    lvalid = 1'b0;
    cur = '0;
    np_req = 1'b0;
    {awv, wv, bry, arv, rry} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `check_eq(level, 6'h00)
    np_req <= 1'b1;
    repeat (40) @(posedge clock);
    np_req <= 1'b0;
    repeat (3) @(posedge clock);
    `check_eq(level, 6'h20)
    np = 32;
    // Every kind in both alignment modes, with the pad Dword forced in and out.
    for (int i = 0; i < 22; i++)
    begin
      if (i == 11)
        axi(1'b1, 12'h000, 32'h00000001, 2'h0, q);
      r.k = kinds[i % 11];
      r.a = {$urandom(), $urandom()};
      r.a[2:0] = {i[0], 2'b00};
      r.n = 11'($urandom_range(1, 8));
      r.f = (r.n > 2) ? 4'hF : 4'($urandom_range(1, 15));
      r.l = (r.n == 1) ? 4'h0 : 4'hF;
      r.z = 1'b0;
      r.e = 1'b0;
      r.tg = $urandom();
      for (int j = 0; j < 8; j++)
        r.p[32 * j +: 32] = $urandom();
      send(r, 1'b0);
      expect_pkt(r, i >= 11, !(r.k inside {[4'h4:4'h6], [4'hC:4'hE]}));
      np -= (r.k <= 4'h7 && r.k != 4'h1) ? 1 : 0;
    end
    `check_eq(level, 6'(np))
    axi(1'b0, 12'h004, 32'h0, 2'h0, q);
    `check_eq(q[5:0], 6'(np))
    r.k = 4'h0;
    r.z = 1'b1;
    r.n = 11'h001;
    send(r, 1'b0);
    expect_pkt(r, 1'b1, 1'b1);
    r.z = 1'b0;
    r.n = 11'h008;
    r.f = 4'h5;
    r.l = 4'hA;
    send(r, 1'b0);
    expect_pkt(r, 1'b1, 1'b0);
    `check_eq(contig(sb0[7:0]), 1'b1)
    r.k = 4'h1;
    r.e = 1'b1;
    r.f = 4'hC;
    r.l = 4'h3;
    send(r, 1'b0);
    expect_pkt(r, 1'b1, 1'b1);
    axi(1'b0, 12'h004, 32'h0, 2'h0, q);
    `check_eq(user_completer_model_inst.dropped, 1)
    `check_eq(q[6], 1'b1)
    `check_eq(user_completer_model_inst.owed_read, 8)
    `check_eq(user_completer_model_inst.owed_io_write, 2)
    `check_eq(user_completer_model_inst.owed_atomic, 6)
    axi(1'b1, 12'h004, 32'h0, 2'h2, q);
    axi(1'b0, 12'h0F0, 32'h0, 2'h2, q);
    `check_eq(q, 32'h00000000)
    // A second reset empties the credit, so Non-Posted requests must wait.
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `check_eq(level, 6'h00)
    r.e = 1'b0;
    r.n = 11'h002;
    r.f = 4'hF;
    r.l = 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      rq[i] = r;
      rq[i].k = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : (i == 2) ? 4'h2 : 4'hC;
      rq[i].tg = $urandom();
      send(rq[i], i < 3);
    end
    expect_pkt(rq[1], 1'b0, 1'b1);
    expect_pkt(rq[3], 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    `check_eq(user_completer_model_inst.beats.size(), 0)
    np_req <= 1'b1;
    repeat (2) @(posedge clock);
    np_req <= 1'b0;
    expect_pkt(rq[0], 1'b0, 1'b1);
    expect_pkt(rq[2], 1'b0, 1'b1);
    repeat (3) @(posedge clock);
    `check_eq(level, 6'h00)
    report_and_stop;
  end
endmodule : testbench
